// ==== rtl/rac_pkg.sv ====
package rac_pkg;
  // Clock and symbol timing
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int SYMBOL_PERIOD_NS = 16000;
  localparam int SYMBOL_CYCLES = (SYMBOL_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [11:0] SYMBOL_LAST = 12'(SYMBOL_CYCLES - 1);
  // Acknowledge timing and averaging length, in symbols
  localparam logic [4:0] ACK_MIN_GAP = 5'h0_0C;
  localparam logic [4:0] SLOT_LAST = 5'h0_13;
  localparam logic [4:0] ACK_START_PHASE = 5'h0_0A;
  localparam logic [4:0] GAP_SAT = 5'h0_1F;
  localparam logic [3:0] AVG_SYMBOLS = 4'h8;
  // Register byte offsets
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CHANNEL = 8'h10;
  localparam logic [7:0] REG_SIGNAL = 8'h14;
  localparam logic [7:0] REG_SYNTH_LO = 8'h18;
  localparam logic [7:0] REG_SYNTH_HI = 8'h1C;
  // Control register fields
  localparam int CTL_AUTO_ACK = 0;
  localparam int CTL_SLOTTED = 1;
  localparam int CTL_ACK_IRQ_SEL = 2;
  localparam int CTL_FORCE_PEND = 3;
  localparam int CTL_REG_PD = 4;
  localparam int CTL_CLEAR_CHANNEL_MODE_SELECT = 5;
  localparam logic [1:0] CLEAR_CHANNEL_MODE_SELECT_RESET = 2'h3;
  // Flag register fields
  localparam int FLG_TX_DONE = 0;
  localparam int FLG_REG_UP = 1;
  localparam int FLG_CCA = 2;
  // Status register fields
  localparam int STS_CCA = 8;
  localparam int STS_CCA_VALID = 9;
  localparam int STS_XTAL = 10;
  localparam int STS_PENDING = 11;
  // Channel register fields
  localparam int CH_HYST = 8;
  localparam logic [7:0] THR_RESET = 8'hE0;
  localparam logic [2:0] HYST_RESET = 3'h2;
  localparam logic [7:0] SYNTH_LO_RESET = 8'h65;
  localparam logic [1:0] SYNTH_HI_RESET = 2'h1;
  localparam logic [11:0] CARRIER_BASE_MHZ = 12'h800;
  // Command codes written to the command register
  localparam logic [3:0] CMD_RX_ON = 4'h1;
  localparam logic [3:0] CMD_TX_ON = 4'h2;
  localparam logic [3:0] CMD_TX_IF_CLEAR = 4'h3;
  localparam logic [3:0] CMD_RF_OFF = 4'h4;
  localparam logic [3:0] CMD_ACK_PEND_CLEAR = 4'h5;
  localparam logic [3:0] CMD_ACK_PEND_SET = 4'h6;
  localparam logic [3:0] CMD_SYNTH_CAL = 4'h7;
  localparam logic [3:0] CMD_SYNTH_CAL_NOW = 4'h8;
  // Radio operating states, value is the readable state number
  typedef enum logic [3:0] {
    ST_OFF, ST_SYNTH_READY, ST_RX, ST_RX_FRAME, ST_TX, ST_ACK_WAIT, ST_ACK_TX
  } rac_radio_type;
  // Events and samples from the modem, same clock
  typedef struct packed {
    logic sfd; logic frameEnd; logic crcOk; logic ackRequest; logic [7:0] seq;
    logic [7:0] rssi; logic [6:0] corr; logic txDone;
  } rac_modem_in_type;
  // Controls toward modem, synthesizer and regulator
  typedef struct packed {
    logic txStart; logic ackStart; logic ackPending; logic [7:0] ackSeq; logic synthStart;
    logic regulatorEnable; logic receiverOn; logic [9:0] synthWord; logic [11:0] carrierMhz;
  } rac_radio_out_type;
endpackage

// ==== rtl/rac_radio_control.sv ====
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module rac_radio_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem side, same clock
  input wire rac_pkg::rac_modem_in_type modemIn,
  output rac_pkg::rac_radio_out_type radioOut,
  // Analog status pins, asynchronous
  input wire logic regulatorReady,
  input wire logic crystalStable
);

  // Whole module state
  typedef struct packed {
    rac_pkg::rac_radio_type radio;
    logic [11:0] symCount;
    logic tick;
    logic automatic_ack_enable;
    logic slotted;
    logic ackIrqSel;
    logic forcePending;
    logic regPowerdown;
    logic [1:0] ccaMode;
    logic [7:0] ccaThr;
    logic [2:0] ccaHyst;
    logic [7:0] synthLo;
    logic [1:0] synthHi;
    logic flagTxDone;
    logic flagRegUp;
    logic flagCca;
    logic pendingHeld;
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [1:0] syncC;
    logic [1:0] pinLevel;
    logic regUpPrev;
    logic frameCrcOk;
    logic ackArmed;
    logic [7:0] frameSeq;
    logic [4:0] sinceEnd;
    logic [4:0] slotPhase;
    logic [10:0] rssiAcc;
    logic [2:0] rssiCnt;
    logic [7:0] rssiVal;
    logic [9:0] corrAcc;
    logic [3:0] corrCnt;
    logic [6:0] corrVal;
    logic [3:0] rxSymbols;
    logic energyClear;
    logic cca;
    logic ccaPrev;
    rac_pkg::rac_radio_out_type out;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rac_state_type;

  rac_state_type r;
  rac_state_type next_r;

  // Outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign radioOut = r.out;

  // Next state of the whole block
  always_comb begin
    logic access;
    logic setup;
    logic wr;
    logic [3:0] cmd;
    logic [1:0] pinDiff;
    logic [10:0] rssiSum;
    logic [9:0] corrSum;
    logic signed [8:0] rssiS;
    logic signed [8:0] thrS;
    logic ccaValid;
    logic notReceiving;
    logic modeClear;
    logic ackGo;
    logic [9:0] word;
    logic [31:0] rd;
    logic mapped;
    next_r = r;
    access = psel & penable & r.pready;
    setup = psel & ~penable;
    wr = access & pwrite;
    cmd = (wr && paddr == rac_pkg::REG_COMMAND) ? pwdata[3:0] : 4'h0;
    pinDiff = 2'h0;
    rssiSum = 11'h000;
    corrSum = 10'h000;
    rssiS = 9'sh000;
    thrS = 9'sh000;
    ackGo = 1'b0;
    rd = 32'h0000_0000;
    mapped = 1'b0;
    ccaValid = 1'b0;
    notReceiving = 1'b0;
    modeClear = 1'b0;
    word = 10'h000;
    // One-cycle pulses default low
    next_r.out.txStart = 1'b0;
    next_r.out.ackStart = 1'b0;
    next_r.out.synthStart = 1'b0;

    next_r.tick = 1'b0;
    if (r.symCount == rac_pkg::SYMBOL_LAST) begin
      next_r.symCount = 12'h000;
      next_r.tick = 1'b1;
    end else begin
      next_r.symCount = r.symCount + 12'h001;
    end

    // Pin synchronisers, level accepted when second and third stages agree
    next_r.syncA = {crystalStable, regulatorReady};
    next_r.syncB = r.syncA;
    next_r.syncC = r.syncB;
    pinDiff = r.syncB ^ r.syncC;
    next_r.pinLevel = (r.syncB & ~pinDiff) | (r.pinLevel & pinDiff);

    // Register writes; only rst clears configuration, so it survives sleep
    // configuration retained
    if (wr && paddr == rac_pkg::REG_CONTROL) begin
      next_r.automatic_ack_enable = pwdata[rac_pkg::CTL_AUTO_ACK];
      next_r.slotted = pwdata[rac_pkg::CTL_SLOTTED];
      next_r.ackIrqSel = pwdata[rac_pkg::CTL_ACK_IRQ_SEL];
      next_r.forcePending = pwdata[rac_pkg::CTL_FORCE_PEND];
      next_r.regPowerdown = pwdata[rac_pkg::CTL_REG_PD];
      next_r.ccaMode = pwdata[rac_pkg::CTL_CLEAR_CHANNEL_MODE_SELECT +: 2];
    end
    if (wr && paddr == rac_pkg::REG_CHANNEL) begin
      next_r.ccaThr = pwdata[7:0];
      next_r.ccaHyst = pwdata[rac_pkg::CH_HYST +: 3];
    end
    if (wr && paddr == rac_pkg::REG_SYNTH_LO) begin
      next_r.synthLo = pwdata[7:0];
    end
    if (wr && paddr == rac_pkg::REG_SYNTH_HI) begin
      next_r.synthHi = pwdata[1:0];
    end
    // Write one to clear; the set terms below come later and win
    if (wr && paddr == rac_pkg::REG_FLAGS) begin
      if (pwdata[rac_pkg::FLG_TX_DONE]) next_r.flagTxDone = 1'b0;
      if (pwdata[rac_pkg::FLG_REG_UP]) next_r.flagRegUp = 1'b0;
      if (pwdata[rac_pkg::FLG_CCA]) next_r.flagCca = 1'b0;
    end

    // regulator up flag on ready edge
    next_r.regUpPrev = r.pinLevel[0];
    if (r.pinLevel[0] && !r.regUpPrev) begin
      next_r.flagRegUp = 1'b1;
    end

    // block average of eight symbol samples
    if (r.tick && r.out.receiverOn) begin
      rssiSum = r.rssiAcc + {{3{modemIn.rssi[7]}}, modemIn.rssi};
      next_r.rssiCnt = r.rssiCnt + 3'h1;
      if (r.rssiCnt == 3'h7) begin
        next_r.rssiVal = rssiSum[10:3];
        next_r.rssiAcc = 11'h000;
      end else begin
        next_r.rssiAcc = rssiSum;
      end
    end

    if (r.tick && r.out.receiverOn && r.rxSymbols != rac_pkg::AVG_SYMBOLS) begin
      next_r.rxSymbols = r.rxSymbols + 4'h1;
    end
    ccaValid = r.out.receiverOn && r.rxSymbols == rac_pkg::AVG_SYMBOLS;

    rssiS = $signed({r.rssiVal[7], r.rssiVal});
    thrS = $signed({r.ccaThr[7], r.ccaThr});
    if (r.energyClear) begin
      next_r.energyClear = rssiS < thrS;
    end else begin
      next_r.energyClear = rssiS < (thrS - $signed({6'h00, r.ccaHyst}));
    end

    notReceiving = r.radio != rac_pkg::ST_RX_FRAME;
    case (r.ccaMode)
      2'h1: modeClear = r.energyClear;
      2'h2: modeClear = notReceiving;
      2'h3: modeClear = r.energyClear & notReceiving;
      // Reserved mode never reports clear, the safe side
      default: modeClear = 1'b0;
    endcase
    next_r.cca = ccaValid & modeClear;
    next_r.ccaPrev = r.cca;
    if (r.cca && !r.ccaPrev) begin
      next_r.flagCca = 1'b1;
    end

    if (modemIn.sfd && r.radio == rac_pkg::ST_RX) begin
      next_r.corrAcc = 10'h000;
      next_r.corrCnt = 4'h0;
    end else if (r.tick && r.corrCnt != rac_pkg::AVG_SYMBOLS) begin
      corrSum = r.corrAcc + {3'h0, modemIn.corr};
      next_r.corrAcc = corrSum;
      next_r.corrCnt = r.corrCnt + 4'h1;
      if (r.corrCnt == 4'h7) begin
        next_r.corrVal = corrSum[9:3];
      end
    end

    // Acknowledge gap counters
    if (r.tick && r.sinceEnd != rac_pkg::GAP_SAT) begin
      next_r.sinceEnd = r.sinceEnd + 5'h01;
    end
    // backoff slot phase from received SFD
    if (modemIn.sfd && r.radio == rac_pkg::ST_RX) begin
      next_r.slotPhase = 5'h00;
    end else if (r.tick) begin
      next_r.slotPhase = (r.slotPhase == rac_pkg::SLOT_LAST) ? 5'h00 : r.slotPhase + 5'h01;
    end

    // pending held by the two strobes
    if (cmd == rac_pkg::CMD_ACK_PEND_SET) next_r.pendingHeld = 1'b1;
    if (cmd == rac_pkg::CMD_ACK_PEND_CLEAR) next_r.pendingHeld = 1'b0;

    if (r.slotted) begin
      ackGo = r.tick && r.sinceEnd >= rac_pkg::ACK_MIN_GAP
              && r.slotPhase == rac_pkg::ACK_START_PHASE;
    end else begin
      ackGo = r.tick && r.sinceEnd >= rac_pkg::ACK_MIN_GAP;
    end

    // state moves on strobes, modem events and the ack gap timer
    case (r.radio)
      rac_pkg::ST_OFF, rac_pkg::ST_SYNTH_READY: begin
        if (cmd == rac_pkg::CMD_TX_ON) begin
          next_r.radio = rac_pkg::ST_TX;
          next_r.out.txStart = 1'b1;
        end
      end
      rac_pkg::ST_RX: begin
        if (modemIn.sfd) begin
          next_r.radio = rac_pkg::ST_RX_FRAME;
          next_r.ackArmed = 1'b0;
        end else if (cmd == rac_pkg::CMD_TX_ON ||
                     (cmd == rac_pkg::CMD_TX_IF_CLEAR && r.cca)) begin
          next_r.radio = rac_pkg::ST_TX;
          next_r.out.txStart = 1'b1;
        // manual ack needs a good CRC
        end else if ((cmd == rac_pkg::CMD_ACK_PEND_SET || cmd == rac_pkg::CMD_ACK_PEND_CLEAR)
                     && r.frameCrcOk) begin
          next_r.radio = rac_pkg::ST_ACK_WAIT;
        end
      end
      rac_pkg::ST_RX_FRAME: begin
        if (cmd == rac_pkg::CMD_ACK_PEND_SET || cmd == rac_pkg::CMD_ACK_PEND_CLEAR) begin
          next_r.ackArmed = 1'b1;
        end
        if (modemIn.frameEnd) begin
          next_r.frameSeq = modemIn.seq;
          next_r.frameCrcOk = modemIn.crcOk;
          next_r.sinceEnd = 5'h00;
          // automatic ack only on good CRC
          if (modemIn.crcOk && ((r.automatic_ack_enable && modemIn.ackRequest) || r.ackArmed)) begin
            next_r.radio = rac_pkg::ST_ACK_WAIT;
          end else begin
            next_r.radio = rac_pkg::ST_RX;
          end
        end
      end
      rac_pkg::ST_ACK_WAIT: begin
        if (ackGo) begin
          next_r.radio = rac_pkg::ST_ACK_TX;
          next_r.out.ackStart = 1'b1;
          next_r.out.ackPending = r.pendingHeld | r.forcePending;
          next_r.out.ackSeq = r.frameSeq;
          next_r.frameCrcOk = 1'b0;
        end
      end
      rac_pkg::ST_ACK_TX: begin
        if (modemIn.txDone) begin
          next_r.radio = rac_pkg::ST_RX;
          next_r.rxSymbols = 4'h0;
          if (r.ackIrqSel) next_r.flagTxDone = 1'b1;
        end
      end
      rac_pkg::ST_TX: begin
        if (modemIn.txDone) begin
          next_r.radio = rac_pkg::ST_RX;
          next_r.rxSymbols = 4'h0;
          next_r.flagTxDone = 1'b1;
        end
      end
      default: next_r.radio = rac_pkg::ST_OFF;
    endcase

    // Strobes that apply from several states
    if (cmd == rac_pkg::CMD_RX_ON && r.radio != rac_pkg::ST_TX
        && r.radio != rac_pkg::ST_ACK_TX) begin
      next_r.radio = rac_pkg::ST_RX;
      next_r.rxSymbols = 4'h0;
      next_r.out.synthStart = 1'b1;
    end
    // calibrate and hold until transmit strobe
    if ((cmd == rac_pkg::CMD_SYNTH_CAL && r.radio != rac_pkg::ST_TX
         && r.radio != rac_pkg::ST_ACK_TX) || cmd == rac_pkg::CMD_SYNTH_CAL_NOW) begin
      next_r.radio = rac_pkg::ST_SYNTH_READY;
      next_r.out.synthStart = 1'b1;
    end
    if (cmd == rac_pkg::CMD_RF_OFF) begin
      next_r.radio = rac_pkg::ST_OFF;
    end

    // regulator on when powerdown bit is zero
    next_r.out.regulatorEnable = ~r.regPowerdown;
    next_r.out.receiverOn = r.radio == rac_pkg::ST_RX || r.radio == rac_pkg::ST_RX_FRAME;
    word = {r.synthHi, r.synthLo};
    next_r.out.synthWord = word;
    next_r.out.carrierMhz = rac_pkg::CARRIER_BASE_MHZ + {2'h0, word};

    // Read mux, loaded in the setup cycle
    case (paddr)
      rac_pkg::REG_COMMAND: mapped = 1'b1;
      rac_pkg::REG_CONTROL: begin
        mapped = 1'b1;
        rd[rac_pkg::CTL_AUTO_ACK] = r.automatic_ack_enable;
        rd[rac_pkg::CTL_SLOTTED] = r.slotted;
        rd[rac_pkg::CTL_ACK_IRQ_SEL] = r.ackIrqSel;
        rd[rac_pkg::CTL_FORCE_PEND] = r.forcePending;
        rd[rac_pkg::CTL_REG_PD] = r.regPowerdown;
        rd[rac_pkg::CTL_CLEAR_CHANNEL_MODE_SELECT +: 2] = r.ccaMode;
      end
      rac_pkg::REG_FLAGS: begin
        mapped = 1'b1;
        rd[rac_pkg::FLG_TX_DONE] = r.flagTxDone;
        rd[rac_pkg::FLG_REG_UP] = r.flagRegUp;
        rd[rac_pkg::FLG_CCA] = r.flagCca;
      end
      rac_pkg::REG_STATUS: begin
        mapped = 1'b1;
        rd[3:0] = r.radio;
        rd[rac_pkg::STS_CCA] = r.cca;
        rd[rac_pkg::STS_CCA_VALID] = ccaValid;
        rd[rac_pkg::STS_XTAL] = r.pinLevel[1];
        rd[rac_pkg::STS_PENDING] = r.pendingHeld;
      end
      rac_pkg::REG_CHANNEL: begin
        mapped = 1'b1;
        rd[7:0] = r.ccaThr;
        rd[rac_pkg::CH_HYST +: 3] = r.ccaHyst;
      end
      rac_pkg::REG_SIGNAL: begin
        mapped = 1'b1;
        rd[7:0] = r.rssiVal;
        rd[14:8] = r.corrVal;
      end
      rac_pkg::REG_SYNTH_LO: begin
        mapped = 1'b1;
        rd[7:0] = r.synthLo;
      end
      rac_pkg::REG_SYNTH_HI: begin
        mapped = 1'b1;
        rd[1:0] = r.synthHi;
      end
      default: mapped = 1'b0;
    endcase
    // One wait-free access phase; ready drops after it
    next_r.pready = setup;
    next_r.pslverr = setup & ~mapped;
    if (setup) begin
      next_r.prdata = rd;
    end
  end

  // State register; config reset values only at rst
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.radio <= rac_pkg::ST_OFF;
      r.regPowerdown <= 1'b1;
      r.ccaMode <= rac_pkg::CLEAR_CHANNEL_MODE_SELECT_RESET;
      r.ccaThr <= rac_pkg::THR_RESET;
      r.ccaHyst <= rac_pkg::HYST_RESET;
      r.synthLo <= rac_pkg::SYNTH_LO_RESET;
      r.synthHi <= rac_pkg::SYNTH_HI_RESET;
      // Frequency outputs already agree with the reset word
      r.out.synthWord <= {rac_pkg::SYNTH_HI_RESET, rac_pkg::SYNTH_LO_RESET};
      r.out.carrierMhz <= rac_pkg::CARRIER_BASE_MHZ
                          + {2'h0, rac_pkg::SYNTH_HI_RESET, rac_pkg::SYNTH_LO_RESET};
      r.energyClear <= 1'b1;
      r.sinceEnd <= rac_pkg::GAP_SAT;
      r.corrCnt <= rac_pkg::AVG_SYMBOLS;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ==== verification/rac_radio_control_sva.sv ====
`timescale 1ns/1ps
// Port-level checker for the radio control block
module rac_radio_control_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Modem and analog side
  input wire rac_pkg::rac_modem_in_type modemIn,
  input wire rac_pkg::rac_radio_out_type radioOut,
  input wire logic regulatorReady,
  input wire logic crystalStable
);
  localparam int SC = rac_pkg::SYMBOL_CYCLES;
  // Completed command write and its code
  logic cmdWr;
  logic [3:0] code;
  assign cmdWr = psel && penable && pready && pwrite && paddr == rac_pkg::REG_COMMAND;
  assign code = pwdata[3:0];
  // Shadows of last frame and control bits
  logic lastCrc;
  logic [7:0] lastSeq;
  logic forceBit;
  logic pdBit;
  logic [31:0] sinceEnd;
  // Saturating count so an ack with no frame fails
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastCrc <= 1'b0;
      lastSeq <= 8'h00;
      forceBit <= 1'b0;
      pdBit <= 1'b1;
      sinceEnd <= 32'hFFFF_FFFF;
    end else begin
      if (modemIn.frameEnd) begin
        lastCrc <= modemIn.crcOk;
        lastSeq <= modemIn.seq;
      end
      if (psel && penable && pready && pwrite && paddr == rac_pkg::REG_CONTROL) begin
        forceBit <= pwdata[rac_pkg::CTL_FORCE_PEND];
        pdBit <= pwdata[rac_pkg::CTL_REG_PD];
      end
      sinceEnd <= modemIn.frameEnd ? 32'h0000_0000 : sinceEnd + 32'(sinceEnd != '1);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_carrier_sum: assert property (
    radioOut.carrierMhz == rac_pkg::CARRIER_BASE_MHZ + {2'h0, radioOut.synthWord})
    else $error("carrier is not base plus word");
  chk_tx_cause: assert property (radioOut.txStart |->
    $past(cmdWr && (code == rac_pkg::CMD_TX_ON || code == rac_pkg::CMD_TX_IF_CLEAR)))
    else $error("transmit start without transmit strobe");
  chk_synth_cause: assert property (radioOut.synthStart |->
    $past(cmdWr && (code == rac_pkg::CMD_SYNTH_CAL || code == rac_pkg::CMD_SYNTH_CAL_NOW
    || code == rac_pkg::CMD_RX_ON)))
    else $error("synth start without calibrate strobe");
  chk_cal_no_tx: assert property (
    cmdWr && code == rac_pkg::CMD_SYNTH_CAL |=> !radioOut.txStart [*2])
    else $error("calibrate strobe started transmit");
  chk_ack_crc: assert property (radioOut.ackStart |-> lastCrc)
    else $error("ack after failed checksum");
  chk_ack_window: assert property (radioOut.ackStart |->
    sinceEnd >= 12 * SC - 1 && sinceEnd < 32 * SC)
    else $error("ack outside symbol window");
  chk_ack_seq: assert property (radioOut.ackStart |=> radioOut.ackSeq == lastSeq)
    else $error("ack sequence differs from frame");
  chk_ack_force: assert property (radioOut.ackStart && forceBit |=> radioOut.ackPending)
    else $error("forced pending not sent");
  chk_reg_enable: assert property (radioOut.regulatorEnable == !$past(pdBit))
    else $error("regulator enable not inverse of powerdown");
  chk_off_rx: assert property (
    cmdWr && code == rac_pkg::CMD_RF_OFF |-> ##[1:3] !radioOut.receiverOn)
    else $error("receiver still on after off strobe");
  // Main scenarios seen
  cover property (radioOut.ackStart);
  cover property (radioOut.txStart);
  cover property (pready && pslverr);
endmodule

// ==== verification/rac_modem_model.sv ====
`timescale 1ns/1ps
// Behavioural modem, regulator and crystal
module rac_modem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Controls in, modem events out
  input wire rac_pkg::rac_radio_out_type radioOut,
  output rac_pkg::rac_modem_in_type modemIn,
  // Analog status levels
  output logic regulatorReady,
  output logic crystalStable
);
  int cyc = 0;
  int regCnt = 0;
  int txWait = 0;
  int endCyc = 0;
  // Quiet channel, fixed correlation
  initial begin
    modemIn = '0;
    modemIn.rssi = 8'hB0;
    modemIn.corr = 7'h55;
    regulatorReady = 1'b0;
    crystalStable = 1'b0;
  end
  // Crystal settles, regulator ramps, transmit ends
  always @(posedge clock) begin
    cyc <= cyc + 1;
    crystalStable <= (cyc > 30);
    regCnt <= (radioOut.regulatorEnable && !rst) ? regCnt + 1 : 0;
    regulatorReady <= (regCnt > 10);
    txWait <= (radioOut.txStart || radioOut.ackStart) ? 20 : (txWait > 0 ? txWait - 1 : 0);
    modemIn.txDone <= (txWait == 1);
  end
  // One frame; result lines invert once released
  task frame(input logic crc, input logic [7:0] s);
    @(posedge clock) modemIn.sfd <= 1'b1;
    @(posedge clock) modemIn.sfd <= 1'b0;
    repeat (50) @(posedge clock);
    modemIn.frameEnd <= 1'b1;
    modemIn.crcOk <= crc;
    modemIn.seq <= s;
    modemIn.ackRequest <= 1'b1;
    endCyc = cyc + 1;
    @(posedge clock) modemIn.frameEnd <= 1'b0;
    modemIn.crcOk <= ~crc;
    modemIn.seq <= ~s;
    modemIn.ackRequest <= 1'b0;
  endtask
endmodule

// ==== verification/test_radio_ack_cca_control.sv ====
`timescale 1ns/1ps
// Register-level bench for the radio control block
module test_radio_ack_cca_control;
  localparam int SC = rac_pkg::SYMBOL_CYCLES;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  rac_pkg::rac_modem_in_type modemIn;
  rac_pkg::rac_radio_out_type radioOut;
  logic regulatorReady, crystalStable;
  int errCount = 0, checks = 0, cyc = 0, txCnt = 0, synCnt = 0, ackCnt = 0, ackCyc = 0, i;
  always #2 clock = ~clock;
  rac_radio_control u_rac_radio_control (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modemIn(modemIn), .radioOut(radioOut),
    .regulatorReady(regulatorReady), .crystalStable(crystalStable));
  rac_modem_model u_rac_modem_model (.clock(clock), .rst(rst), .radioOut(radioOut),
    .modemIn(modemIn), .regulatorReady(regulatorReady), .crystalStable(crystalStable));
  // Pulse counters and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (radioOut.txStart === 1'b1) txCnt <= txCnt + 1;
    if (radioOut.synthStart === 1'b1) synCnt <= synCnt + 1;
    if (radioOut.ackStart === 1'b1) begin
      ackCnt <= ackCnt + 1;
      ackCyc <= u_rac_modem_model.cyc;
    end
    if (cyc == 99000) begin
      errCount++;
      conclude();
    end
  end
  task conclude();
    if (errCount == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      $display("BAD %s exp %h got %h", n, x, g);
      errCount++;
    end
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    chk("waits", 0, 32'(n));
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string n);
    apb(0, a, 32'h0000_0000);
    chk(n, x, q & m);
  endtask
  task cmd(input logic [3:0] c);
    apb(1, rac_pkg::REG_COMMAND, 32'(c));
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    // Reset values, unmapped place, frequency word
    rd(rac_pkg::REG_CONTROL, 32'hFFFF_FFFF, 32'h0000_0070, "control");
    rd(rac_pkg::REG_CHANNEL, 32'hFFFF_FFFF, 32'h0000_02E0, "channel");
    rd(rac_pkg::REG_SYNTH_LO, 32'hFFFF_FFFF, 32'h0000_0065, "synthLo");
    chk("carrier", 32'h0000_0965, 32'(radioOut.carrierMhz));
    apb(0, 8'h20, 32'h0000_0000);
    chk("slverr", 1, 32'(e));
    apb(1, rac_pkg::REG_SYNTH_LO, 32'h0000_002A);
    apb(1, rac_pkg::REG_SYNTH_HI, 32'h0000_0002);
    repeat (3) @(posedge clock);
    chk("carrier", 32'h0000_0A2A, 32'(radioOut.carrierMhz));
    apb(1, rac_pkg::REG_STATUS, 32'h0000_0005);
    rd(rac_pkg::REG_STATUS, 32'h0000_000F, 32'h0000_0000, "stateRo");
    // Power the regulator, wait for crystal
    apb(1, rac_pkg::REG_CONTROL, 32'h0000_0060);
    repeat (30) @(posedge clock);
    chk("regEn", 1, 32'(radioOut.regulatorEnable));
    rd(rac_pkg::REG_FLAGS, 32'h0000_0002, 32'h0000_0002, "regUp");
    rd(rac_pkg::REG_STATUS, 32'h0000_0400, 32'h0000_0400, "crystal");
    // Calibrate twice, transmit only on strobe
    cmd(rac_pkg::CMD_SYNTH_CAL);
    cmd(rac_pkg::CMD_SYNTH_CAL_NOW);
    rd(rac_pkg::REG_STATUS, 32'h0000_000F, 32'h0000_0001, "synthRdy");
    chk("noTx", 0, txCnt);
    chk("synCnt", 2, synCnt);
    cmd(rac_pkg::CMD_TX_ON);
    rd(rac_pkg::REG_STATUS, 32'h0000_000F, 32'h0000_0004, "tx");
    repeat (30) @(posedge clock);
    rd(rac_pkg::REG_FLAGS, 32'h0000_0001, 32'h0000_0001, "txDone");
    cmd(rac_pkg::CMD_RF_OFF);
    rd(rac_pkg::REG_STATUS, 32'h0000_000F, 32'h0000_0000, "off");
    // Fresh receiver: assessment invalid, conditional strobe ignored
    cmd(rac_pkg::CMD_RX_ON);
    rd(rac_pkg::REG_STATUS, 32'h0000_020F, 32'h0000_0002, "rxNew");
    cmd(rac_pkg::CMD_TX_IF_CLEAR);
    repeat (3) @(posedge clock);
    chk("txIgn", 1, txCnt);
    repeat (9 * SC) @(posedge clock);
    rd(rac_pkg::REG_STATUS, 32'h0000_030F, 32'h0000_0302, "ccaOk");
    rd(rac_pkg::REG_FLAGS, 32'h0000_0004, 32'h0000_0004, "ccaFlag");
    rd(rac_pkg::REG_SIGNAL, 32'h0000_00FF, 32'h0000_00B0, "rssi");
    // Every channel mode, mode 00 never clear
    for (i = 0; i < 4; i++) begin
      apb(1, rac_pkg::REG_CONTROL, 32'(i) << 5);
      repeat (4) @(posedge clock);
      rd(rac_pkg::REG_STATUS, 32'h0000_0100, (i != 0) ? 32'h0000_0100 : 0, "mode");
    end
    cmd(rac_pkg::CMD_TX_IF_CLEAR);
    repeat (3) @(posedge clock);
    chk("txClear", 2, txCnt);
    repeat (40) @(posedge clock);
    cmd(rac_pkg::CMD_RX_ON);
    // Failed frame then good frame, auto ack with forced pending
    apb(1, rac_pkg::REG_CONTROL, 32'h0000_006D);
    apb(1, rac_pkg::REG_FLAGS, 32'h0000_0007);
    u_rac_modem_model.frame(1'b0, 8'h11);
    repeat (100) @(posedge clock);
    u_rac_modem_model.frame(1'b1, 8'h5A);
    i = 0;
    while (ackCnt == 0 && i < 60000) begin
      @(posedge clock);
      i++;
    end
    repeat (2) @(posedge clock);
    chk("ackCnt", 1, ackCnt);
    i = ackCyc - u_rac_modem_model.endCyc;
    chk("ackGap", 1, 32'(i >= 12 * SC && i <= 14 * SC));
    chk("ackSeq", 32'h0000_005A, 32'(radioOut.ackSeq));
    chk("ackPend", 1, 32'(radioOut.ackPending));
    repeat (40) @(posedge clock);
    rd(rac_pkg::REG_FLAGS, 32'h0000_0001, 32'h0000_0001, "ackDone");
    rd(rac_pkg::REG_STATUS, 32'h0000_000F, 32'h0000_0002, "backRx");
    rd(rac_pkg::REG_SIGNAL, 32'h0000_7F00, 32'h0000_5500, "corr");
    cmd(rac_pkg::CMD_ACK_PEND_SET);
    rd(rac_pkg::REG_STATUS, 32'h0000_080F, 32'h0000_0802, "pendSet");
    cmd(rac_pkg::CMD_ACK_PEND_CLEAR);
    rd(rac_pkg::REG_STATUS, 32'h0000_080F, 32'h0000_0002, "pendClr");
    conclude();
  end
endmodule
bind rac_radio_control rac_radio_control_sva u_rac_radio_control_sva (.clock(clock),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .modemIn(modemIn), .radioOut(radioOut), .regulatorReady(regulatorReady),
  .crystalStable(crystalStable));
